// file: rtl/parity_status_pkg.sv
// Purpose: Shared constants for the bridge parity status block
// Assumes: APB register bus, 32-bit data, word-aligned registers
// Notes:   Offsets and field positions are local choices
package parity_status_pkg;
    localparam logic [11:0] OFS_STATUS  = 12'h000;
    localparam logic [11:0] OFS_CONTROL = 12'h004;
    localparam logic [11:0] OFS_EVENT   = 12'h008;
    localparam int BIT_PRI_DET  = 0;
    localparam int BIT_PRI_DPD  = 1;
    localparam int BIT_SEC_DET  = 2;
    localparam int BIT_SEC_DPD  = 3;
    localparam int BIT_PRI_RESP = 0;
    localparam int BIT_SEC_RESP = 1;
    localparam logic [3:0] STATUS_RESET  = 4'h0;
    localparam logic [1:0] CONTROL_RESET = 2'h0;
    typedef enum logic {DIR_DOWN, DIR_UP} dir_t;
    typedef enum logic [1:0] {TX_READ, TX_POSTED, TX_DELAYED} tx_t;
endpackage

// file: rtl/parity_if.sv
// Purpose: Carries one data-phase parity event into the status logic
// Assumes: Event fields are valid while evtValid is high
// Notes:   Pin fields are already synchronised and active high
`timescale 1ns/10ps
interface parity_if;
    logic                        evtValid;
    parity_status_pkg::dir_t     dir;
    logic                        onSecondary;
    logic                        badParity;
    logic                        perrSeen;
    modport src (output evtValid, dir, onSecondary, badParity, perrSeen);
    modport dst (input  evtValid, dir, onSecondary, badParity, perrSeen);
endinterface

// file: rtl/parity_event_sync.sv
// Purpose: Synchronises the two parity-error pins and packs the event
// Assumes: Pins are active low, from outside the sys_clk domain
// Notes:   Adds two cycles of latency on the pin paths
`timescale 1ns/10ps
module parity_event_sync (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rst_b,
    // Raw inputs
    input  wire logic               upPerrPin_b,
    input  wire logic               downPerrPin_b,
    input  wire logic               evtIn,
    input  wire logic               dirUp,
    input  wire logic               onSec,
    input  wire logic               badPar,
    // Event out
    parity_if.src                   evt
);
    logic [1:0] upMeta_q;
    logic [1:0] downMeta_q;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            upMeta_q   <= 2'h3;
            downMeta_q <= 2'h3;
        end else begin
            upMeta_q   <= {upMeta_q[0], upPerrPin_b};
            downMeta_q <= {downMeta_q[0], downPerrPin_b};
        end
    end

    assign evt.evtValid    = evtIn;
    assign evt.dir         = dirUp ? parity_status_pkg::DIR_UP
                                   : parity_status_pkg::DIR_DOWN;
    assign evt.onSecondary = onSec;
    assign evt.badParity   = badPar;
    assign evt.perrSeen    = onSec ? !downMeta_q[1] : !upMeta_q[1];
endmodule

// file: rtl/bridge_parity_status_logic.sv
// Purpose: Parity status bits of both bridge interfaces, APB reachable
// Assumes: Bridge core reports one data-phase event at a time
// Notes:   Pin samples lag the core event by two cycles; the core must
//          hold evtIn until the pin result is meaningful
// Summary of operation
// R1 - Primary bad parity on up-read, down-writes sets primary detect
// R2 - Secondary or other primary errors leave primary detect
// R3 - Secondary bad parity on down-read, up-writes sets secondary detect
// R4 - Primary data-parity bit only when master on primary
// R5 - Primary data-parity bit needs primary response enable
// R6 - Primary trigger: upstream pin low or bad parity
// R7 - Primary data-parity bit only upstream, primary-bus errors
// R8 - Secondary data-parity bit only when master on secondary
// R9 - Secondary data-parity bit needs secondary response enable
// R10 - Secondary trigger: downstream pin low or bad parity
// R11 - Secondary data-parity bit only downstream, secondary errors
// R12 - Bits stay set until written one; reset clears
`timescale 1ns/10ps
module bridge_parity_status_logic (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rst_b,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Parity pins, active low
    input  wire logic               upPerrPin_b,
    input  wire logic               downPerrPin_b,
    // Bridge core event
    input  wire logic               evtIn,
    input  wire logic               dirUp,
    input  wire logic               onSec,
    input  wire logic               badPar,
    input  wire logic [1:0]         txType,
    // Status out
    output logic      [3:0]         statusBits,
    output logic                    priRespEn,
    output logic                    secRespEn
);
    parity_if evt ();
    logic [3:0] status_q;
    logic [3:0] status_d;
    logic [1:0] control_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    logic [3:0]  setMask;
    logic [3:0]  clrMask;
    logic        isUp;
    logic        apbWr;
    logic        apbRd;
    logic        validTx;

    parity_event_sync u_sync (
        .sys_clk       (sys_clk),
        .rst_b         (rst_b),
        .upPerrPin_b   (upPerrPin_b),
        .downPerrPin_b (downPerrPin_b),
        .evtIn         (evtIn),
        .dirUp         (dirUp),
        .onSec         (onSec),
        .badPar        (badPar),
        .evt           (evt)
    );

    function automatic logic addrHit(input logic [11:0] a,
                                     input logic [11:0] ofs);
        addrHit = (a == ofs);
    endfunction

    assign isUp    = (evt.dir == parity_status_pkg::DIR_UP);
    assign validTx = (txType != 2'h3);
    assign apbWr   = psel && penable && pwrite;
    assign apbRd   = psel && !penable && !pwrite;

    // Master on primary only for upstream traffic; secondary for downstream
    always_comb begin
        setMask = 4'h0;
        if (evt.evtValid && validTx) begin
            // Primary target of down writes, master of up reads
            if (!evt.onSecondary && evt.badParity &&
                (isUp == (txType == parity_status_pkg::TX_READ))) begin
                setMask[parity_status_pkg::BIT_PRI_DET] = 1'b1; // [R1] [R2]
            end
            if (evt.onSecondary && evt.badParity &&
                (isUp != (txType == parity_status_pkg::TX_READ))) begin
                setMask[parity_status_pkg::BIT_SEC_DET] = 1'b1; // [R3]
            end
            if (!evt.onSecondary && isUp &&
                control_q[parity_status_pkg::BIT_PRI_RESP] &&
                (evt.perrSeen || evt.badParity)) begin
                setMask[parity_status_pkg::BIT_PRI_DPD] = 1'b1; // [R4] [R5] [R6] [R7]
            end
            if (evt.onSecondary && !isUp &&
                control_q[parity_status_pkg::BIT_SEC_RESP] &&
                (evt.perrSeen || evt.badParity)) begin
                setMask[parity_status_pkg::BIT_SEC_DPD] = 1'b1; // [R8] [R9] [R10] [R11]
            end
        end
    end

    assign clrMask = (apbWr && addrHit(paddr, parity_status_pkg::OFS_STATUS))
                     ? pwdata[3:0] : 4'h0;
    // Set wins over a same-cycle clear so no event is lost
    assign status_d = (status_q & ~clrMask) | setMask; // [R12]

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_q <= parity_status_pkg::STATUS_RESET; // [R12]
        end else begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            control_q <= parity_status_pkg::CONTROL_RESET;
        end else if (apbWr && addrHit(paddr, parity_status_pkg::OFS_CONTROL)) begin
            control_q <= pwdata[1:0];
        end
    end

    // Read data captured in setup so the access phase answers at once
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata_q  <= 32'h0;
            pslverr_q <= 1'b0;
        end else if (psel && !penable) begin
            pslverr_q <= !(addrHit(paddr, parity_status_pkg::OFS_STATUS) ||
                           addrHit(paddr, parity_status_pkg::OFS_CONTROL));
            if (apbRd && addrHit(paddr, parity_status_pkg::OFS_STATUS)) begin
                prdata_q <= {28'h0, status_q};
            end else if (apbRd &&
                         addrHit(paddr, parity_status_pkg::OFS_CONTROL)) begin
                prdata_q <= {30'h0, control_q};
            end else begin
                prdata_q <= 32'h0;
            end
        end
    end

    logic [3:0] statusOut_q;
    logic [1:0] controlOut_q;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            statusOut_q  <= parity_status_pkg::STATUS_RESET;
            controlOut_q <= parity_status_pkg::CONTROL_RESET;
        end else begin
            statusOut_q  <= status_d;
            controlOut_q <= control_q;
        end
    end

    assign prdata     = prdata_q;
    assign pready     = 1'b1;
    assign pslverr    = pslverr_q;
    assign statusBits = statusOut_q;
    assign priRespEn  = controlOut_q[parity_status_pkg::BIT_PRI_RESP];
    assign secRespEn  = controlOut_q[parity_status_pkg::BIT_SEC_RESP];

    a_pri_det_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
        setMask[0] |=> status_q[0]) else $error("pri detect not set"); // [R1]
    a_pri_det_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (evt.evtValid && evt.onSecondary && !clrMask[0]) |=>
        $stable(status_q[0]) || $rose(status_q[0]) == 1'b0)
        else $error("pri detect changed"); // [R2]
    a_sec_det_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
        setMask[2] |=> status_q[2]) else $error("sec detect not set"); // [R3]
    a_pri_dpd_dir: assert property (@(posedge sys_clk) disable iff (!rst_b)
        setMask[1] |-> isUp && !evt.onSecondary)
        else $error("pri dpd wrong dir"); // [R4]
    a_pri_dpd_en: assert property (@(posedge sys_clk) disable iff (!rst_b)
        setMask[1] |-> control_q[0]) else $error("pri dpd no enable"); // [R5]
    a_pri_dpd_trig: assert property (@(posedge sys_clk) disable iff (!rst_b)
        setMask[1] |-> (evt.perrSeen || evt.badParity))
        else $error("pri dpd no trigger"); // [R6]
    a_pri_dpd_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
        setMask[1] |=> status_q[1]) else $error("pri dpd lost"); // [R7]
    a_sec_dpd_dir: assert property (@(posedge sys_clk) disable iff (!rst_b)
        setMask[3] |-> !isUp && evt.onSecondary)
        else $error("sec dpd wrong dir"); // [R8]
    a_sec_dpd_en: assert property (@(posedge sys_clk) disable iff (!rst_b)
        setMask[3] |-> control_q[1]) else $error("sec dpd no enable"); // [R9]
    a_sec_dpd_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
        setMask[3] |=> status_q[3]) else $error("sec dpd lost"); // [R10] [R11]
    a_status_sticky: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (status_q != 4'h0 && clrMask == 4'h0) |=>
        ((status_q & $past(status_q)) == $past(status_q)))
        else $error("status bit dropped"); // [R12]

    c_pri_det: cover property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(status_q[0]));
    c_sec_dpd: cover property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(status_q[3]));
    c_clear: cover property (@(posedge sys_clk) disable iff (!rst_b)
        $fell(status_q[1]));
endmodule

// file: sim/pci_agent_model.sv
// Purpose: Far-side PCI agent that drives the two parity-error pins
// Assumes: Pins are pulled up, so a released pin reads high
// Notes:   Changes only just after a rising edge, as a real agent does
`timescale 1ns/10ps
module pci_agent_model (
    // Clock
    input  wire logic sys_clk,
    // Requests from the bench
    input  wire logic perrReq,
    input  wire logic onSecBus,
    // Pins, active low
    output logic      upPerrPin_b,
    output logic      downPerrPin_b
);
    initial begin
        upPerrPin_b   = 1'b1;
        downPerrPin_b = 1'b1;
    end
    // A target reports bad data only on the bus it sits on
    always @(posedge sys_clk) begin
        upPerrPin_b   <= !(perrReq && !onSecBus);
        downPerrPin_b <= !(perrReq && onSecBus);
    end
endmodule

// file: sim/test_bridge_parity_status_logic.sv
// Purpose: Self-checking bench for the bridge parity status block
// Assumes: Zero-wait APB slave, pins synchronised over two cycles
// Notes:   Reset read and refusal first, then row table, sticky and reset cases
`timescale 1ns/10ps
module test_bridge_parity_status_logic;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        upPerrPin_b;
    logic        downPerrPin_b;
    logic        evtIn = 1'b0;
    logic        dirUp = 1'b0;
    logic        onSec = 1'b0;
    logic        badPar = 1'b0;
    logic        perrReq = 1'b0;
    logic [1:0]  txType = 2'h0;
    logic [3:0]  statusBits;
    logic        priRespEn;
    logic        secRespEn;
    logic [31:0] rd;
    logic        err;
    int          errorCnt = 0;
    int          samplesChecked = 0;
    // Row: up, onSec, badPar, pinLow, txType[1:0], control[1:0], status[3:0]
    logic [11:0] rows [20] = '{12'h230, 12'h63C, 12'hA33, 12'hE30, 12'h271,
        12'h678, 12'hA72, 12'hE74, 12'h2B1, 12'h6B8, 12'hAB2, 12'hEB4,
        12'hA01, 12'h604, 12'h650, 12'hA60, 12'h972, 12'h578, 12'hD70,
        12'h130};

    always #50 sys_clk = ~sys_clk;

    bridge_parity_status_logic u_dut (.sys_clk(sys_clk), .rst_b(rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .upPerrPin_b(upPerrPin_b),
        .downPerrPin_b(downPerrPin_b), .evtIn(evtIn), .dirUp(dirUp),
        .onSec(onSec), .badPar(badPar), .txType(txType),
        .statusBits(statusBits), .priRespEn(priRespEn),
        .secRespEn(secRespEn));

    pci_agent_model u_agent (.sys_clk(sys_clk), .perrReq(perrReq),
        .onSecBus(onSec), .upPerrPin_b(upPerrPin_b),
        .downPerrPin_b(downPerrPin_b));

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        samplesChecked++;
        if (got !== exp) begin
            errorCnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait on a stuck slave
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Pin goes low early enough to pass the two-flop synchroniser
    task automatic runRow(input logic [11:0] r);
        apb(parity_status_pkg::OFS_CONTROL, 1'b1, {30'h0, r[5:4]});
        perrReq <= r[8];
        onSec <= r[10];
        repeat (3) @(posedge sys_clk);
        evtIn <= 1'b1;
        dirUp <= r[11];
        badPar <= r[9];
        txType <= r[7:6];
        @(posedge sys_clk);
        evtIn <= 1'b0;
        perrReq <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask

    task automatic tallyAndFinish;
        if (errorCnt == 0 && samplesChecked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #(6000 * 100);
        errorCnt++;
        tallyAndFinish();
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        apb(parity_status_pkg::OFS_STATUS, 1'b0, 32'h0);
        chk("status reset", 32'h0, rd);
        chk("status err", 32'h0, {31'h0, err});
        apb(parity_status_pkg::OFS_EVENT, 1'b1, 32'hFFFFFFFF);
        apb(parity_status_pkg::OFS_EVENT, 1'b0, 32'h0);
        chk("unmapped data", 32'h0, rd);
        chk("unmapped err", 32'h1, {31'h0, err});
        foreach (rows[i]) begin
            apb(parity_status_pkg::OFS_STATUS, 1'b1, 32'hF);
            runRow(rows[i]);
            chk("respEn", {30'h0, rows[i][5:4]}, {secRespEn, priRespEn});
            chk("statusBits", {28'h0, rows[i][3:0]}, {28'h0, statusBits});
            apb(parity_status_pkg::OFS_STATUS, 1'b0, 32'h0);
            chk("status", {28'h0, rows[i][3:0]}, rd);
        end
        // Bits hold through a clean event and a zero write
        apb(parity_status_pkg::OFS_STATUS, 1'b1, 32'hF);
        runRow(12'hA33);
        runRow(12'h830);
        apb(parity_status_pkg::OFS_STATUS, 1'b1, 32'h0);
        apb(parity_status_pkg::OFS_STATUS, 1'b0, 32'h0);
        chk("sticky", 32'h3, rd);
        apb(parity_status_pkg::OFS_STATUS, 1'b1, 32'h1);
        apb(parity_status_pkg::OFS_STATUS, 1'b0, 32'h0);
        chk("clear one", 32'h2, rd);
        runRow(12'h63C);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk("status in reset", 32'h0, {28'h0, statusBits});
        chk("pready in reset", 32'h1, {31'h0, pready});
        rst_b <= 1'b1;
        apb(parity_status_pkg::OFS_STATUS, 1'b0, 32'h0);
        chk("status after reset", 32'h0, rd);
        apb(parity_status_pkg::OFS_CONTROL, 1'b0, 32'h0);
        chk("control after reset", 32'h0, rd);
        tallyAndFinish();
    end
endmodule
